// file: rtl/cmd_parser_consts.vh
// constants for the multidrop ascii command parser: offsets, codes, timing
// assumes a 10 MHz mclk and byte addressed avalon-mm with 32-bit data
`ifndef CMD_PARSER_CONSTS_VH
`define CMD_PARSER_CONSTS_VH

// clock and serial timing
`define CLK_HZ            10000000
`define BAUD_SLOWEST      1200
`define BAUD_DIV_SLOWEST  (`CLK_HZ / `BAUD_SLOWEST)
`define TX_DELAY_RST      16'h0064

// string limits
`define MAX_STRING_LEN    9'h100
`define MAX_PARAM_CHARS   4'h8
`define MAX_BUS_ADDR      8'h7f

// ascii codes
`define CH_CR             8'h0d
`define CH_DOLLAR         8'h24
`define CH_COMMA          8'h2c
`define CH_PLUS           8'h2b
`define CH_MINUS          8'h2d
`define CH_DOT            8'h2e
`define CH_SPACE          8'h20
`define CH_ZERO           8'h30
`define CH_NINE           8'h39
`define CH_UPPER_A        8'h41
`define CH_UPPER_Z        8'h5a
`define CH_LOWER_A        8'h61
`define CH_LOWER_Z        8'h7a
`define CH_S              8'h53
`define CH_U              8'h55
`define CH_FOUR           8'h34

// register byte offsets
`define REG_CTRL          5'h00
`define REG_STATUS        5'h04
`define REG_CMD           5'h08
`define REG_PARAM_LO      5'h0c
`define REG_PARAM_HI      5'h10
`define REG_TX_DELAY      5'h14

// control register fields and reset value
`define CTRL_REMOTE_BIT   0
`define CTRL_MD_EN_BIT    1
`define CTRL_REMOTE_RST   1'b0

// status code bit positions (weights 1,2,8,16,32,64,128)
`define ST_REMOTE         0
`define ST_UNLOCK         1
`define ST_CHAR_ERR       3
`define ST_DATA_ERR       4
`define ST_LOST           5
`define ST_EXT_REF        6
`define ST_MUTE           7

`endif

// file: rtl/multidrop_ascii_command_parser.v
// multidrop_ascii_command_parser: decodes ascii command strings from a shared line
// assumes switches and rx line are asynchronous pins; status inputs are on mclk
// Notes on behaviour
// [RULE1] serial commands execute only in remote mode; panel control only in local mode
// [RULE2] own bus address 0..127 is taken from the address switches after reset
// [RULE3] one switch position is no address bit; it sets the multidrop default
// [RULE4] the serial parameter switches set the serial port rate
// [RULE5] multidrop-off command gives point-to-point; multidrop-on restores addressing
// [RULE6] a command code is one letter; comma and dollar only for addressing
// [RULE7] parameter characters follow the letter and are collected before execution
// [RULE8] carriage return ends every string
// [RULE9] lower-case letters in a string are invalid
// [RULE10] commands execute only while the unit is selected
// [RULE11] select indicator lights whenever the unit is addressed
// [RULE12] dollar plus decimal address selects the unit on a match
// [RULE13] comma-separated address list selects the unit if any entry matches
// [RULE14] selection persists across strings until the next addressing
// [RULE15] an unaddressed unit ignores all following commands
// [RULE16] a selected unit finding a string error drops the command and de-selects; a data error on the carriage return keeps the selection
// [RULE17] a string holds at most 256 characters including the carriage return
// [RULE18] baud rate and transmit drive delay are configurable
// [RULE19] responses end with S and the decimal sum of status flag weights
// [RULE20] badly formatted data de-selects and discards input until carriage return; a data error on the carriage return itself does not de-select
// [RULE21] interrogations are ignored while more than one unit is addressed
// [RULE22] an over-long string is a lost-data error; input discarded until return
// [RULE23] with multidrop off the unit counts as always selected
//
// Our own choices: the address map and register access over Avalon-MM.
`timescale 1ns/1ns
`include "cmd_parser_consts.vh"
module multidrop_ascii_command_parser #(
    parameter BAUD_DIV_MAX = `BAUD_DIV_SLOWEST
) (
    // clock and reset
    input  wire        mclk,
    input  wire        rst_n,
    // avalon-mm slave
    input  wire [4:0]  address,
    input  wire        read,
    input  wire        write,
    input  wire [31:0] writedata,
    output reg  [31:0] readdata,
    output wire        waitrequest,
    // serial line
    input  wire        controller_to_unit_line,
    output wire        unit_to_controller_line,
    output wire        unit_to_controller_line_oe_n,
    // rear switches
    input  wire [7:0]  serial_param_switches,
    input  wire [6:0]  bus_address_switches,
    input  wire        multidrop_default_switch,
    // receiver state feeding the status code
    input  wire        synth_unlock,
    input  wire        ext_ref,
    input  wire        mute_active,
    // panel and executed commands
    output wire        select_led,
    output wire        panel_enable,
    output reg         cmd_valid,
    output reg  [7:0]  cmd_code,
    output reg  [63:0] cmd_param,
    output reg  [3:0]  cmd_param_len
);
    localparam P_START   = 2'd0;
    localparam P_ADDR    = 2'd1;
    localparam P_PARAM   = 2'd2;
    localparam P_DISCARD = 2'd3;
    localparam T_IDLE  = 3'd0;
    localparam T_WAIT  = 3'd1;
    localparam T_S     = 3'd2;
    localparam T_HUND  = 3'd3;
    localparam T_TENS  = 3'd4;
    localparam T_ONES  = 3'd5;
    localparam T_CR    = 3'd6;

    // synchronised switches and strap capture
    reg  [15:0] sw_s1;
    reg  [15:0] sw_s2;
    reg         strap_done_reg;
    reg  [6:0]  own_addr_reg;
    // control and configuration
    reg         remote_reg;
    reg         md_en_reg;
    reg  [15:0] tx_delay_reg;
    reg         ack_reg;
    // parser
    reg  [1:0]  pstate_reg;
    reg  [8:0]  len_reg;
    reg  [7:0]  num_reg;
    reg         have_digit_reg;
    reg         match_acc_reg;
    reg  [1:0]  addr_cnt_reg;
    reg         sel_reg;
    reg         multi_reg;
    reg         pend_reg;
    reg  [7:0]  pcode_reg;
    reg  [63:0] pparam_reg;
    reg  [3:0]  plen_reg;
    reg  [7:0]  cur_err_reg;
    reg  [7:0]  last_err_reg;
    // responder
    reg  [2:0]  tstate_reg;
    reg  [15:0] tdly_reg;
    reg  [7:0]  snap_reg;
    reg         tx_go_reg;
    reg  [7:0]  tx_byte_reg;

    wire [7:0]  rx_data;
    wire        rx_valid;
    wire        rx_frame_err;
    wire        tx_busy;
    wire [15:0] baud_div;
    wire [7:0]  status_code;
    wire [7:0]  b = rx_data;
    wire        is_cr    = (b == `CH_CR);
    wire        is_digit = (b >= `CH_ZERO) && (b <= `CH_NINE);
    wire        is_upper = (b >= `CH_UPPER_A) && (b <= `CH_UPPER_Z);
    wire        is_lower = (b >= `CH_LOWER_A) && (b <= `CH_LOWER_Z);
    wire        is_pchar = is_digit || (b == `CH_DOT) || (b == `CH_PLUS)
                           || (b == `CH_MINUS) || (b == `CH_SPACE);
    wire        sel_eff  = ~md_en_reg | sel_reg;  // [RULE23]
    wire [7:0]  num_next = (num_reg * 8'd10) + (b - `CH_ZERO);
    // an S right after U is its argument, not a new command
    wire        u_arg    = (pcode_reg == `CH_U) && (plen_reg == 4'd0) && (b == `CH_S);

    assign waitrequest  = (read | write) & ~ack_reg;
    assign select_led   = sel_eff;  // [RULE11]
    assign panel_enable = ~remote_reg;  // [RULE1]
    // rate from the switches: slowest-rate divisor halved per step
    wire [31:0] baud_full = BAUD_DIV_MAX >> sw_s2[10:8];
    assign baud_div     = baud_full[15:0];  // [RULE4]
    assign status_code  = {mute_active, ext_ref, last_err_reg[5:3], 1'b0,
                           synth_unlock, remote_reg};  // [RULE19]

    serial_port u_port (
        .mclk         (mclk),
        .rst_n        (rst_n),
        .rx_pin       (controller_to_unit_line),
        .tx_line      (unit_to_controller_line),
        .tx_oe_n      (unit_to_controller_line_oe_n),
        .baud_div     (baud_div),
        .rx_data      (rx_data),
        .rx_valid     (rx_valid),
        .rx_frame_err (rx_frame_err),
        .tx_start     (tx_go_reg),
        .tx_data      (tx_byte_reg),
        .tx_busy      (tx_busy)
    );

    // byte classification for the current character
    reg  err_data;
    reg  err_char;
    reg  err_lost;
    reg  fin_num;
    reg  addr_end;
    reg  exec_now;
    always @* begin
        err_char = rx_frame_err || (rx_valid && is_lower);  // [RULE9]
        err_lost = rx_valid && !is_cr && (len_reg == `MAX_STRING_LEN - 9'd1);  // [RULE17] [RULE22]
        err_data = 1'b0;
        fin_num  = 1'b0;
        addr_end = 1'b0;
        exec_now = 1'b0;
        if (rx_valid && !is_lower) begin
            case (pstate_reg)
                P_START: err_data = !(is_cr || is_upper || b == `CH_DOLLAR);  // [RULE6]
                P_ADDR: begin
                    fin_num  = have_digit_reg && (is_cr || is_upper || b == `CH_COMMA);
                    addr_end = is_cr || is_upper;
                    err_data = !(is_digit || fin_num)
                               || (is_digit && num_next > `MAX_BUS_ADDR)
                               || (is_digit && num_reg > 8'd12);
                end
                P_PARAM: begin
                    exec_now = pend_reg && !u_arg
                               && (is_cr || is_upper || b == `CH_DOLLAR);  // [RULE7]
                    err_data = !(exec_now || is_pchar || u_arg)
                               || (is_pchar && plen_reg == `MAX_PARAM_CHARS);
                end
                default: err_data = 1'b0;
            endcase
        end
    end

    wire any_err = (err_char || err_data || err_lost) && pstate_reg != P_DISCARD;
    wire interrog = (plen_reg == 4'd0);
    wire allowed  = remote_reg && sel_eff  // [RULE1] [RULE10] [RULE15]
                    && !(interrog && md_en_reg && multi_reg);  // [RULE21]
    wire do_exec  = exec_now && !any_err && allowed;

    // switch synchroniser and strap capture after reset release
    always @(posedge mclk) begin
        sw_s1 <= {serial_param_switches, multidrop_default_switch, bus_address_switches};
        sw_s2 <= sw_s1;  // runs through reset so the capture sees settled pins
        if (!rst_n) begin
            strap_done_reg <= 1'b0;
            own_addr_reg   <= 7'h00;
        end else if (!strap_done_reg) begin
            strap_done_reg <= 1'b1;
            own_addr_reg   <= sw_s2[6:0];  // [RULE2]
        end
    end

    // parser: addressing, parameters, errors, string length
    always @(posedge mclk) begin
        if (!rst_n) begin
            pstate_reg     <= P_START;
            len_reg        <= 9'h000;
            num_reg        <= 8'h00;
            have_digit_reg <= 1'b0;
            match_acc_reg  <= 1'b0;
            addr_cnt_reg   <= 2'd0;
            sel_reg        <= 1'b0;
            multi_reg      <= 1'b0;
            pend_reg       <= 1'b0;
            pcode_reg      <= 8'h00;
            pparam_reg     <= 64'h0;
            plen_reg       <= 4'd0;
            cur_err_reg    <= 8'h00;
            last_err_reg   <= 8'h00;
        end else if (rx_valid || rx_frame_err) begin
            len_reg <= len_reg + 9'h001;
            if (is_cr && rx_valid) begin  // [RULE8]
                len_reg      <= 9'h000;
                pstate_reg   <= P_START;
                pend_reg     <= 1'b0;
                last_err_reg <= cur_err_reg | {2'b00, err_data, err_char, 3'b000};
                cur_err_reg  <= 8'h00;
            end else if (any_err) begin
                pstate_reg <= P_DISCARD;  // [RULE20] [RULE22]
                pend_reg   <= 1'b0;
                if (sel_reg) begin
                    sel_reg <= 1'b0;  // [RULE16]
                end
                cur_err_reg <= cur_err_reg | {2'b00, err_lost, err_data, err_char, 3'b000};
            end else if (pstate_reg != P_DISCARD) begin
                if (b == `CH_DOLLAR) begin
                    pstate_reg     <= P_ADDR;
                    num_reg        <= 8'h00;
                    have_digit_reg <= 1'b0;
                    match_acc_reg  <= 1'b0;
                    addr_cnt_reg   <= 2'd0;
                    pend_reg       <= 1'b0;
                end else if (is_upper && !(u_arg && pstate_reg == P_PARAM)) begin
                    pstate_reg <= P_PARAM;
                    pend_reg   <= 1'b1;
                    pcode_reg  <= b;
                    pparam_reg <= 64'h0;
                    plen_reg   <= 4'd0;
                end else if (is_digit && pstate_reg == P_ADDR) begin
                    num_reg        <= num_next;
                    have_digit_reg <= 1'b1;
                end else if (pstate_reg == P_ADDR) begin
                    num_reg        <= 8'h00;  // comma closes one list entry
                    have_digit_reg <= 1'b0;
                end else begin
                    pparam_reg <= {pparam_reg[55:0], b};  // [RULE7]
                    plen_reg   <= plen_reg + 4'd1;
                end
            end
            if (fin_num && !any_err) begin
                match_acc_reg <= match_acc_reg | (num_reg[6:0] == own_addr_reg);  // [RULE13]
                if (addr_cnt_reg != 2'd2) begin
                    addr_cnt_reg <= addr_cnt_reg + 2'd1;
                end
            end
            if (addr_end && !any_err) begin
                // selection is loaded here, at the end of an address list, and cleared on any error except a data error on the carriage return
                sel_reg   <= match_acc_reg | (num_reg[6:0] == own_addr_reg);  // [RULE12] [RULE14]
                multi_reg <= (addr_cnt_reg != 2'd0);
            end
        end
    end

    // executed command outputs and multidrop mode commands
    always @(posedge mclk) begin
        if (!rst_n) begin
            cmd_valid     <= 1'b0;
            cmd_code      <= 8'h00;
            cmd_param     <= 64'h0;
            cmd_param_len <= 4'd0;
            remote_reg    <= `CTRL_REMOTE_RST;
            md_en_reg     <= 1'b1;
        end else begin
            cmd_valid <= do_exec;
            if (!strap_done_reg) begin
                md_en_reg <= ~sw_s2[7];  // [RULE3]
            end
            if (do_exec) begin
                cmd_code      <= pcode_reg;
                cmd_param     <= pparam_reg;
                cmd_param_len <= plen_reg;
                if (pcode_reg == `CH_U && plen_reg == 4'd1) begin
                    if (pparam_reg[7:0] == `CH_FOUR) begin
                        md_en_reg <= 1'b1;  // [RULE5]
                    end else if (pparam_reg[7:0] == `CH_S) begin
                        md_en_reg <= 1'b0;  // [RULE5]
                    end
                end
            end
            if (write && ack_reg && address == `REG_CTRL) begin
                remote_reg <= writedata[`CTRL_REMOTE_BIT];
                md_en_reg  <= writedata[`CTRL_MD_EN_BIT];
            end
        end
    end

    // responder: drive delay, then S, decimal status, carriage return
    always @(posedge mclk) begin
        if (!rst_n) begin
            tstate_reg  <= T_IDLE;
            tdly_reg    <= 16'h0000;
            snap_reg    <= 8'h00;
            tx_go_reg   <= 1'b0;
            tx_byte_reg <= 8'h00;
        end else begin
            tx_go_reg <= 1'b0;
            case (tstate_reg)
                T_IDLE: begin
                    if (do_exec && interrog) begin
                        tstate_reg <= T_WAIT;
                        tdly_reg   <= tx_delay_reg;  // [RULE18]
                        snap_reg   <= status_code;
                    end
                end
                T_WAIT: begin
                    if (tdly_reg != 16'h0000) begin
                        tdly_reg <= tdly_reg - 16'h0001;
                    end else begin
                        tstate_reg <= T_S;
                    end
                end
                default: begin
                    if (!tx_busy && !tx_go_reg) begin
                        tx_go_reg  <= 1'b1;
                        tstate_reg <= tstate_reg + 3'd1;
                        case (tstate_reg)
                            T_S:    tx_byte_reg <= `CH_S;  // [RULE19]
                            T_HUND: tx_byte_reg <= `CH_ZERO + (snap_reg / 8'd100);
                            T_TENS: tx_byte_reg <= `CH_ZERO + ((snap_reg / 8'd10) % 8'd10);
                            T_ONES: tx_byte_reg <= `CH_ZERO + (snap_reg % 8'd10);
                            default: begin
                                tx_byte_reg <= `CH_CR;
                                tstate_reg  <= T_IDLE;
                            end
                        endcase
                        // leading zeros are skipped
                        if (tstate_reg == T_HUND && snap_reg < 8'd100) begin
                            tx_go_reg  <= 1'b0;
                        end
                        if (tstate_reg == T_TENS && snap_reg < 8'd10) begin
                            tx_go_reg  <= 1'b0;
                        end
                    end
                end
            endcase
        end
    end

    // avalon slave: one wait cycle, registered read data
    always @(posedge mclk) begin
        if (!rst_n) begin
            ack_reg      <= 1'b0;
            readdata     <= 32'h0;
            tx_delay_reg <= `TX_DELAY_RST;
        end else begin
            ack_reg <= (read | write) & ~ack_reg;
            if (write && ack_reg && address == `REG_TX_DELAY) begin
                tx_delay_reg <= writedata[15:0];  // [RULE18]
            end
            if (read && !ack_reg) begin
                case (address)
                    `REG_CTRL:     readdata <= {30'h0, md_en_reg, remote_reg};
                    `REG_STATUS:   readdata <= {sw_s2[15:8], 1'b0, own_addr_reg, 5'h00,
                                                md_en_reg, multi_reg, sel_eff, status_code};
                    `REG_CMD:      readdata <= {15'h0, interrog, 4'h0, cmd_param_len, cmd_code};
                    `REG_PARAM_LO: readdata <= cmd_param[31:0];
                    `REG_PARAM_HI: readdata <= cmd_param[63:32];
                    `REG_TX_DELAY: readdata <= {16'h0, tx_delay_reg};
                    default:       readdata <= 32'h0;
                endcase
            end
        end
    end
endmodule

// file: rtl/serial_port.v
// serial_port: 8n1 receiver and transmitter sharing one baud divisor
// assumes the rx pin is asynchronous to mclk; tx requests come from mclk logic
`timescale 1ns/1ns
module serial_port (
    // clock and reset
    input  wire        mclk,
    input  wire        rst_n,
    // line side
    input  wire        rx_pin,
    output reg         tx_line,
    output wire        tx_oe_n,
    // rate
    input  wire [15:0] baud_div,
    // receive side
    output reg  [7:0]  rx_data,
    output reg         rx_valid,
    output reg         rx_frame_err,
    // transmit side
    input  wire        tx_start,
    input  wire [7:0]  tx_data,
    output wire        tx_busy
);
    localparam R_IDLE  = 2'd0;
    localparam R_START = 2'd1;
    localparam R_DATA  = 2'd2;
    localparam R_STOP  = 2'd3;

    reg        rx_s1;
    reg        rx_s2;
    reg [1:0]  rstate_reg;
    reg [15:0] rcnt_reg;
    reg [2:0]  rbit_reg;
    reg [7:0]  rsh_reg;
    reg [9:0]  tsh_reg;
    reg [3:0]  tbits_reg;
    reg [15:0] tcnt_reg;

    assign tx_busy = (tbits_reg != 4'd0);
    assign tx_oe_n = ~tx_busy;  // drive the shared line only while sending

    // two-stage synchroniser on the line
    always @(posedge mclk) begin
        if (!rst_n) begin
            rx_s1 <= 1'b1;
            rx_s2 <= 1'b1;
        end else begin
            rx_s1 <= rx_pin;
            rx_s2 <= rx_s1;
        end
    end

    // receiver: find start edge, sample mid-bit
    always @(posedge mclk) begin
        if (!rst_n) begin
            rstate_reg   <= R_IDLE;
            rcnt_reg     <= 16'h0000;
            rbit_reg     <= 3'd0;
            rsh_reg      <= 8'h00;
            rx_data      <= 8'h00;
            rx_valid     <= 1'b0;
            rx_frame_err <= 1'b0;
        end else begin
            rx_valid     <= 1'b0;
            rx_frame_err <= 1'b0;
            case (rstate_reg)
                R_IDLE: begin
                    if (!rx_s2) begin
                        rcnt_reg   <= {1'b0, baud_div[15:1]};
                        rstate_reg <= R_START;
                    end
                end
                R_START: begin
                    if (rcnt_reg != 16'h0000) begin
                        rcnt_reg <= rcnt_reg - 16'h0001;
                    end else if (!rx_s2) begin
                        rcnt_reg   <= baud_div;
                        rbit_reg   <= 3'd0;
                        rstate_reg <= R_DATA;
                    end else begin
                        rstate_reg <= R_IDLE;  // glitch, not a start bit
                    end
                end
                R_DATA: begin
                    if (rcnt_reg != 16'h0000) begin
                        rcnt_reg <= rcnt_reg - 16'h0001;
                    end else begin
                        rsh_reg  <= {rx_s2, rsh_reg[7:1]};
                        rcnt_reg <= baud_div;
                        rbit_reg <= rbit_reg + 3'd1;
                        if (rbit_reg == 3'd7) begin
                            rstate_reg <= R_STOP;
                        end
                    end
                end
                default: begin
                    if (rcnt_reg != 16'h0000) begin
                        rcnt_reg <= rcnt_reg - 16'h0001;
                    end else begin
                        rx_data      <= rsh_reg;
                        rx_valid     <= rx_s2;
                        rx_frame_err <= ~rx_s2;
                        rstate_reg   <= R_IDLE;
                    end
                end
            endcase
        end
    end

    // transmitter: start bit, eight data bits lsb first, stop bit
    always @(posedge mclk) begin
        if (!rst_n) begin
            tsh_reg   <= 10'h3ff;
            tbits_reg <= 4'd0;
            tcnt_reg  <= 16'h0000;
            tx_line   <= 1'b1;
        end else if (!tx_busy) begin
            tx_line <= 1'b1;
            if (tx_start) begin
                tsh_reg   <= {1'b1, tx_data, 1'b0};
                tbits_reg <= 4'd10;
                tcnt_reg  <= baud_div;
            end
        end else begin
            tx_line <= tsh_reg[0];
            if (tcnt_reg != 16'h0000) begin
                tcnt_reg <= tcnt_reg - 16'h0001;
            end else begin
                tsh_reg   <= {1'b1, tsh_reg[9:1]};
                tbits_reg <= tbits_reg - 4'd1;
                tcnt_reg  <= baud_div;
            end
        end
    end
endmodule

// file: tb/cmd_parser_chk.sv
// checker: port relations of the command parser
// assumes one mclk domain, bound below
`timescale 1ns/1ns
module cmd_parser_chk (
    // watched ports
    input wire        mclk,
    input wire        rst_n,
    input wire        unit_to_controller_line,
    input wire        unit_to_controller_line_oe_n,
    input wire        select_led,
    input wire        panel_enable,
    input wire        cmd_valid,
    input wire [7:0]  cmd_code,
    input wire [63:0] cmd_param,
    input wire [3:0]  cmd_param_len
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // command outputs against mode, selection and format; serial line idle level
    property p_remote; cmd_valid |-> !panel_enable; endproperty
    a_remote: assert property (p_remote) else $error("run in local");
    property p_sel; cmd_valid |-> $past(select_led); endproperty
    a_sel: assert property (p_sel) else $error("run unselected");
    property p_code; cmd_valid |-> cmd_code inside {[8'h41:8'h5a]}; endproperty
    a_code: assert property (p_code) else $error("bad code");
    property p_len; cmd_valid |-> cmd_param_len <= 4'h8; endproperty
    a_len: assert property (p_len) else $error("bad length");
    property p_hold; !cmd_valid |-> $stable(cmd_code) && $stable(cmd_param); endproperty
    a_hold: assert property (p_hold) else $error("command moved");
    property p_pulse; cmd_valid |=> !cmd_valid; endproperty
    a_pulse: assert property (p_pulse) else $error("long pulse");
    property p_idle; unit_to_controller_line_oe_n |-> unit_to_controller_line; endproperty
    a_idle: assert property (p_idle) else $error("line not idle");
    property p_param;
        cmd_valid && cmd_param_len != 4'h0 && cmd_code != 8'h55
        |-> cmd_param[7:0] inside {[8'h30:8'h39], 8'h2e, 8'h2b, 8'h2d, 8'h20};
    endproperty
    a_param: assert property (p_param) else $error("bad param");
endmodule
bind multidrop_ascii_command_parser cmd_parser_chk u_cmd_parser_chk (.mclk, .rst_n,
    .unit_to_controller_line, .unit_to_controller_line_oe_n, .select_led, .panel_enable,
    .cmd_valid, .cmd_code, .cmd_param, .cmd_param_len);

// file: tb/ctl_model.sv
// partner: remote controller sending 8n1 strings
// assumes BIT mclk cycles per bit, line idles high
`timescale 1ns/1ns
module ctl_model #(
    parameter BIT = 16
) (
    input  wire  mclk,
    output logic line
);
    initial line = 1'b1;
    // one frame, lsb first
    task automatic send_byte(input logic [7:0] b);
        integer i;
        line <= 1'b0;
        repeat (BIT) @(posedge mclk);
        for (i = 0; i < 8; i++) begin
            line <= b[i];
            repeat (BIT) @(posedge mclk);
        end
        line <= 1'b1;
        repeat (BIT) @(posedge mclk);
    endtask
    // string then carriage return
    task automatic send_str(input string s);
        integer k;
        for (k = 0; k < s.len(); k++) send_byte(s[k]);
        send_byte(8'h0d);
    endtask
endmodule

// file: tb/testbench.sv
// testbench: register and string tests of the parser
// assumes address switches 10, multidrop default on
`timescale 1ns/1ns
module testbench;
    logic        mclk = 1'b0;
    logic        rst_n = 1'b0;
    logic        read = 1'b0;
    logic        write = 1'b0;
    logic        unlock = 1'b0;
    logic        md_sw = 1'b0;
    logic [6:0]  own_sw = 7'h0a;
    logic [4:0]  address = 5'h00;
    logic [31:0] writedata = 32'h0;
    logic [31:0] readdata, q;
    logic        waitrequest, line, select_led, panel_enable, cmd_valid;
    logic [7:0]  cmd_code;
    logic [63:0] cmd_param;
    int          fail_count = 0, n_checks = 0, n_cmd = 0, cyc = 0;
    initial forever #50 mclk = ~mclk;
    // count commands, cut hangs
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cmd_valid === 1'b1) n_cmd <= n_cmd + 1;
        if (cyc == 20000) begin
            fail_count++;
            end_sim();
        end
    end
    ctl_model #(.BIT(17)) u_ctl_model (.mclk, .line);
    multidrop_ascii_command_parser #(.BAUD_DIV_MAX(16)) u_multidrop_ascii_command_parser (
        .mclk, .rst_n, .address, .read, .write, .writedata, .readdata, .waitrequest,
        .controller_to_unit_line(line), .unit_to_controller_line(),
        .unit_to_controller_line_oe_n(), .serial_param_switches(8'h00),
        .bus_address_switches(own_sw), .multidrop_default_switch(md_sw),
        .synth_unlock(unlock), .ext_ref(1'b0), .mute_active(1'b0), .select_led,
        .panel_enable, .cmd_valid, .cmd_code, .cmd_param, .cmd_param_len());
    task chk(input logic [79:0] got, input logic [79:0] exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // avalon access, held until waitrequest low
    task bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        address <= a;
        writedata <= d;
        read <= ~w;
        write <= w;
        @(posedge mclk);
        while (waitrequest !== 1'b0) @(posedge mclk);
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
        @(posedge mclk);
    endtask
    task str(input string s);
        u_ctl_model.send_str(s);
        repeat (4) @(posedge mclk);
    endtask
    task end_sim;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge mclk);
        rst_n <= 1'b1;
        unlock <= 1'b1;
        repeat (3) @(posedge mclk);
        chk(panel_enable, 1);
        bus(0, 5'h00, 0);
        chk(q, 32'h2);
        bus(0, 5'h14, 0);
        chk(q, 32'h64);
        bus(0, 5'h18, 0);
        chk(q, 0);
        str("$10D3");
        chk(n_cmd, 0);
        bus(1, 5'h00, 32'h3);
        str("$5D3");
        chk({n_cmd[3:0], select_led}, 0);
        str("$7,10D3");
        chk({n_cmd[3:0], select_led, cmd_code, cmd_param}, {5'h3, 8'h44, 64'h33});
        bus(0, 5'h04, 0);
        chk({q[22:8], q[1:0]}, {15'h0a07, 2'h3});
        str("D2");
        chk({n_cmd[3:0], cmd_param}, {4'h2, 64'h32});
        str("d2");
        chk({n_cmd[3:0], select_led}, {4'h2, 1'b0});
        str("$10US");
        str("$5");
        chk(select_led, 1);
        str("U4");
        chk(select_led, 0);
        end_sim();
    end
endmodule
